// >>> hw/fsp_pkg.sv
// Constants and types for the flash SPI program port
// How it works
// - Read-status and write-status carry exactly one data byte of the status register.
// - Read takes two address bytes, then shifts out stored bytes from there.
// - Info-page select bit steers reads to the information page.
// - Read address auto-increments while selected and wraps from top to zero.
// - Main area reads return data only while readback disable is clear.
// - Program takes two address bytes, then writes data bytes onward from there.
// - Info-page select bit steers program writes to the information page.
// - Write latch must be set first; no byte is queued for a flash write while it is clear.
// - One program command accepts up to 1024 bytes starting anywhere.
// - Write latch clears when select rises after a program command.
// - Page erase takes one page byte; 0-31 code, 32-35 data pages.
// - Page erase starts on select rise only if the write latch was set.
// - While erasing, every command except read-status is ignored.
// - Write latch clears when a page erase completes.
// - Erase-all starts on select rise; info page too only if bit 3 set.
// - Read-protect-config returns one byte holding the page protection config.
// - Readback disable blocks main access and info writes; info reads still allowed.
// - Readback disable needs the write latch; afterwards SPI control is refused.
// - Debug enable with write latch sets debug until a full erase.
// - Protected restart maps the protected area from address zero.
// - Protected restart places SRAM at 0x8000 whatever the location control says.
// - Odd count of ones in top 16 data bytes selects protected start.
// - Opcodes 0x06, 0x04, 0x05, 0x01, 0x03, 0x02 for latch, status, read, program.
// - Opcodes 0x52, 0x62, 0x89, 0x85, 0x86 for erases, protect read, disable, debug.
// - Write latch is clear after power-up.
// - Address and data go low byte first, each byte MSB first.
package fsp_pkg;
    localparam logic [7:0]  OP_SET_WL   = 8'h06;
    localparam logic [7:0]  OP_CLR_WL   = 8'h04;
    localparam logic [7:0]  OP_RD_SR    = 8'h05;
    localparam logic [7:0]  OP_WR_SR    = 8'h01;
    localparam logic [7:0]  OP_READ     = 8'h03;
    localparam logic [7:0]  OP_PROG     = 8'h02;
    localparam logic [7:0]  OP_ERS_PG   = 8'h52;
    localparam logic [7:0]  OP_ERS_ALL  = 8'h62;
    localparam logic [7:0]  OP_RD_PCFG  = 8'h89;
    localparam logic [7:0]  OP_RB_DIS   = 8'h85;
    localparam logic [7:0]  OP_DBG_EN   = 8'h86;
    localparam logic [7:0]  OP_NONE     = 8'h00;
    localparam int          SR_DBG      = 7;
    localparam int          SR_WEN      = 5;
    localparam int          SR_BUSY     = 4;
    localparam int          SR_INFO     = 3;
    localparam int          SR_RDIS     = 2;
    localparam logic [7:0]  LAST_PAGE   = 8'h23;
    localparam int          PAGE_SHIFT  = 9;
    localparam logic [10:0] PROG_MAX    = 11'h400;
    localparam logic [15:0] SRAM_HIGH   = 16'h8000;
    localparam logic [15:0] SRAM_LOW    = 16'h0000;
    localparam logic [15:0] ADDR_ZERO   = 16'h0000;
    localparam int          UNPROTECTED_PAGE_COUNT_W      = 7;
    localparam int          NV_TOP_W    = 16 * 8;
    localparam int          FIFO_D      = 16;
    localparam int          CLK_MHZ     = 20;
    localparam int          ERASE_US    = 20;
    localparam logic [15:0] ERASE_CYC   = 16'(ERASE_US * CLK_MHZ);
    typedef enum logic [2:0] {
        FSP_OP   = 3'b000,
        FSP_A0   = 3'b001,
        FSP_A1   = 3'b011,
        FSP_DATA = 3'b010,
        FSP_IGN  = 3'b110
    } fsp_phase_t;
    typedef struct packed {
        logic        info;
        logic [15:0] addr;
        logic [7:0]  data;
    } fsp_wr_t;
endpackage : fsp_pkg

// >>> hw/fsp_top.sv
// Flash SPI program port with its write FIFO
`timescale 1ns/10ps
module fsp_fifo
    import fsp_pkg::*;
#(
    parameter int W = 8,
    parameter int D = FIFO_D
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } fsp_fifo_st_t;
    fsp_fifo_st_t f_q;
    fsp_fifo_st_t f_d;
    logic [AW:0]  used;

    assign used      = f_q.wp - f_q.rp;
    assign in_ready  = (used != (AW+1)'(D));
    assign out_valid = (used != '0);
    assign out_data  = f_q.mem[f_q.rp[AW-1:0]];

    always_comb begin
        f_d = f_q;
        if (in_valid && in_ready) begin
            f_d.mem[f_q.wp[AW-1:0]] = in_data;
            f_d.wp = f_q.wp + (AW+1)'(1);
        end
        if (out_valid && out_ready) begin
            f_d.rp = f_q.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule : fsp_fifo

module fsp_top
    import fsp_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                SYS_RST,
    input  wire logic                SPI_SCK,
    input  wire logic                SPI_MOSI,
    input  wire logic                FLASH_CHIP_SELECT_N,
    output logic                     SPI_MISO,
    output logic                     SPI_MISO_OE,
    input  wire logic [7:0]          FLASH_RDATA,
    input  wire logic                FLASH_READY,
    input  wire logic [7:0]          PROTECT_CONFIG_REG,
    input  wire logic [NV_TOP_W-1:0] NV_TOP,
    input  wire logic                SRAM_LOCATION_CTRL,
    output logic                     FLASH_RD,
    output logic [15:0]              FLASH_RD_ADDR,
    output logic                     FLASH_RD_INFO,
    output logic                     FLASH_WR,
    output logic [15:0]              FLASH_WR_ADDR,
    output logic [7:0]               FLASH_WR_DATA,
    output logic                     FLASH_WR_INFO,
    output logic                     FLASH_ERASE_PAGE,
    output logic                     FLASH_ERASE_ALL,
    output logic                     FLASH_ERASE_INFO,
    output logic [5:0]               FLASH_PAGE,
    output logic [7:0]               FLASH_STATUS_REG,
    output logic                     READBACK_DISABLE,
    output logic                     DEBUG_EN,
    output logic                     PROG_OVERRUN,
    output logic                     PROTECTED_START_SELECT,
    output logic [15:0]              CODE_REMAP_BASE,
    output logic [15:0]              SRAM_BASE
);
    typedef struct packed {
        logic        sck_m;
        logic        sck_s;
        logic        sck_p;
        logic        mosi_m;
        logic        mosi_s;
        logic        cs_m;
        logic        cs_s;
        logic        cs_p;
        fsp_phase_t  phase;
        logic [7:0]  op;
        logic        go;
        logic [7:0]  sh;
        logic [2:0]  bitc;
        logic [7:0]  tx;
        logic        miso;
        logic        miso_oe;
        logic [15:0] addr;
        logic [10:0] cnt;
        logic        wen;
        logic        info;
        logic        rdis;
        logic        dbg;
        logic        ers_pg;
        logic        ers_all;
        logic        ers_info;
        logic [5:0]  page;
        logic [15:0] etmr;
        logic        rd;
        logic        rdv;
        logic [15:0] rd_addr;
        logic        rd_info;
        logic        wr;
        fsp_wr_t     wrq;
        logic [7:0]  stat;
        logic        ovr;
        logic        started;
        logic        pstart;
        logic [15:0] remap;
        logic [15:0] sram;
    } fsp_state_t;

    fsp_state_t s_q;
    fsp_state_t n;
    logic       rise;
    logic       fall;
    logic       cs_up;
    logic       bdone;
    logic       busy;
    logic       nv_par;
    logic [7:0] rx;
    logic [7:0] sr;
    logic       push;
    fsp_wr_t    push_w;
    logic       f_ready;
    logic       f_valid;
    fsp_wr_t    f_data;
    logic       pop;

    assign rise   = s_q.sck_s && !s_q.sck_p;
    assign fall   = !s_q.sck_s && s_q.sck_p;
    assign cs_up  = s_q.cs_s && !s_q.cs_p;
    assign bdone  = rise && !s_q.cs_s && (s_q.bitc == 3'h7);
    assign rx     = {s_q.sh[6:0], s_q.mosi_s};
    assign busy   = s_q.ers_pg || s_q.ers_all;
    assign nv_par = ^NV_TOP;
    assign pop    = !s_q.wr && f_valid && FLASH_READY;

    // Writes queue here for a slow flash macro; bytes arriving while it is full are dropped and flag overrun
    fsp_fifo #(
        .W ($bits(fsp_wr_t)),
        .D (FIFO_D)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst       (SYS_RST),
        .in_valid  (push),
        .in_data   (push_w),
        .in_ready  (f_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (pop)
    );

    always_comb begin
        n        = s_q;
        push     = 1'b0;
        push_w   = '0;
        n.rd     = 1'b0;
        n.wr     = 1'b0;
        n.rdv    = s_q.rd;
        // Two-stage synchronisers; only the second stage is looked at
        n.sck_m  = SPI_SCK;
        n.sck_s  = s_q.sck_m;
        n.sck_p  = s_q.sck_s;
        n.mosi_m = SPI_MOSI;
        n.mosi_s = s_q.mosi_m;
        n.cs_m   = FLASH_CHIP_SELECT_N;
        n.cs_s   = s_q.cs_m;
        n.cs_p   = s_q.cs_s;

        sr          = 8'h00;
        sr[SR_DBG]  = s_q.dbg;
        sr[SR_WEN]  = s_q.wen;
        sr[SR_BUSY] = busy;
        sr[SR_INFO] = s_q.info;
        sr[SR_RDIS] = s_q.rdis;
        n.stat      = sr;

        if (s_q.cs_s) begin
            n.bitc    = 3'h0;
            n.phase   = FSP_OP;
            n.miso_oe = 1'b0;
        end else begin
            n.miso_oe = 1'b1;
            if (rise) begin
                n.sh   = rx;
                n.bitc = s_q.bitc + 3'h1;
            end
            // No shift on the fall that follows a byte boundary: the MSB was just loaded
            if (fall && (s_q.bitc != 3'h0)) begin
                n.miso = s_q.tx[6];
                n.tx   = {s_q.tx[6:0], 1'b0};
            end
        end

        if (bdone) begin
            unique case (s_q.phase)
                FSP_OP: begin
                    n.op    = rx;
                    n.go    = 1'b0;
                    n.cnt   = 11'h000;
                    n.phase = FSP_DATA;
                    if (busy && (rx != OP_RD_SR)) begin
                        n.op    = OP_NONE;
                        n.phase = FSP_IGN;
                    end else if (s_q.rdis && (rx != OP_RD_SR) && (rx != OP_READ)) begin
                        n.op    = OP_NONE;
                        n.phase = FSP_IGN;
                    end else begin
                        unique case (rx)
                            OP_RD_SR: begin
                                n.tx   = sr;
                                n.miso = sr[7];
                            end
                            OP_RD_PCFG: begin
                                n.tx   = PROTECT_CONFIG_REG;
                                n.miso = PROTECT_CONFIG_REG[7];
                            end
                            OP_WR_SR, OP_ERS_PG: begin
                                n.phase = FSP_DATA;
                            end
                            OP_READ: begin
                                n.phase = FSP_A0;
                            end
                            OP_PROG: begin
                                n.phase = FSP_A0;
                                n.go    = 1'b1;
                                n.ovr   = 1'b0;
                            end
                            OP_SET_WL: begin
                                n.wen   = 1'b1;
                                n.phase = FSP_IGN;
                            end
                            OP_CLR_WL: begin
                                n.wen   = 1'b0;
                                n.phase = FSP_IGN;
                            end
                            OP_ERS_ALL, OP_RB_DIS, OP_DBG_EN: begin
                                n.go    = s_q.wen;
                                n.phase = FSP_IGN;
                            end
                            default: begin
                                n.op    = OP_NONE;
                                n.phase = FSP_IGN;
                            end
                        endcase
                    end
                end
                FSP_A0: begin
                    n.addr[7:0] = rx;
                    n.phase     = FSP_A1;
                end
                FSP_A1: begin
                    n.addr[15:8] = rx;
                    n.phase      = FSP_DATA;
                    if (s_q.op == OP_READ) begin
                        n.rd      = 1'b1;
                        n.rd_addr = {rx, s_q.addr[7:0]};
                        n.rd_info = s_q.info;
                    end
                end
                FSP_DATA: begin
                    unique case (s_q.op)
                        OP_WR_SR: begin
                            n.info  = rx[SR_INFO];
                            n.phase = FSP_IGN;
                        end
                        OP_READ: begin
                            n.addr    = s_q.addr + 16'h0001;
                            n.rd      = 1'b1;
                            n.rd_addr = s_q.addr + 16'h0001;
                            n.rd_info = s_q.info;
                        end
                        OP_PROG: begin
                            if (s_q.wen && (s_q.cnt < PROG_MAX)) begin
                                push        = f_ready;
                                push_w.info = s_q.info;
                                push_w.addr = s_q.addr;
                                push_w.data = rx;
                                n.ovr       = s_q.ovr || !f_ready;
                                n.addr      = s_q.addr + 16'h0001;
                                n.cnt       = s_q.cnt + 11'h001;
                            end
                        end
                        OP_ERS_PG: begin
                            n.page  = rx[5:0];
                            n.go    = s_q.wen && (rx <= LAST_PAGE);
                            n.phase = FSP_IGN;
                        end
                        default: begin
                            n.phase = FSP_IGN;
                        end
                    endcase
                end
                FSP_IGN: begin
                    n.phase = FSP_IGN;
                end
                default: begin
                    n.phase = FSP_IGN;
                end
            endcase
        end

        // Read data lands two cycles after the request, well before the next SCK fall
        if (s_q.rdv) begin
            n.tx   = (s_q.rdis && !s_q.rd_info) ? 8'h00 : FLASH_RDATA;
            n.miso = (s_q.rdis && !s_q.rd_info) ? 1'b0 : FLASH_RDATA[7];
        end

        if (cs_up && s_q.go) begin
            n.go = 1'b0;
            unique case (s_q.op)
                OP_PROG: begin
                    n.wen = 1'b0;
                end
                OP_ERS_PG: begin
                    n.ers_pg = 1'b1;
                    n.etmr   = 16'h0000;
                end
                OP_ERS_ALL: begin
                    n.ers_all  = 1'b1;
                    n.ers_info = s_q.info;
                    n.etmr     = 16'h0000;
                end
                OP_RB_DIS: begin
                    n.rdis = 1'b1;
                    n.wen  = 1'b0;
                end
                OP_DBG_EN: begin
                    n.dbg = 1'b1;
                    n.wen = 1'b0;
                end
                default: begin
                    n.go = 1'b0;
                end
            endcase
        end else if (cs_up) begin
            n.go = 1'b0;
        end

        // Self-timed erase on the device clock
        if (busy) begin
            n.etmr = s_q.etmr + 16'h0001;
            if (s_q.etmr == (ERASE_CYC - 16'h0001)) begin
                n.ers_pg  = 1'b0;
                n.ers_all = 1'b0;
                n.wen     = 1'b0;
                if (s_q.ers_all) begin
                    n.dbg = 1'b0;
                end
            end
        end

        if (pop) begin
            n.wr  = 1'b1;
            n.wrq = f_data;
        end

        // Restart mapping is fixed once, one cycle after reset release
        if (!s_q.started) begin
            n.started = 1'b1;
            n.pstart  = nv_par;
            n.remap   = nv_par ? (16'(PROTECT_CONFIG_REG[UNPROTECTED_PAGE_COUNT_W-1:0]) << PAGE_SHIFT)
                               : ADDR_ZERO;
        end
        n.sram = (s_q.pstart || SRAM_LOCATION_CTRL) ? SRAM_HIGH : SRAM_LOW;
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q      <= '0;
            s_q.cs_m <= 1'b1;
            s_q.cs_s <= 1'b1;
            s_q.cs_p <= 1'b1;
        end else begin
            s_q <= n;
        end
    end

    assign SPI_MISO               = s_q.miso;
    assign SPI_MISO_OE            = s_q.miso_oe;
    assign FLASH_RD               = s_q.rd;
    assign FLASH_RD_ADDR          = s_q.rd_addr;
    assign FLASH_RD_INFO          = s_q.rd_info;
    assign FLASH_WR               = s_q.wr;
    assign FLASH_WR_ADDR          = s_q.wrq.addr;
    assign FLASH_WR_DATA          = s_q.wrq.data;
    assign FLASH_WR_INFO          = s_q.wrq.info;
    assign FLASH_ERASE_PAGE       = s_q.ers_pg;
    assign FLASH_ERASE_ALL        = s_q.ers_all;
    assign FLASH_ERASE_INFO       = s_q.ers_info;
    assign FLASH_PAGE             = s_q.page;
    assign FLASH_STATUS_REG       = s_q.stat;
    assign READBACK_DISABLE       = s_q.rdis;
    assign DEBUG_EN               = s_q.dbg;
    assign PROG_OVERRUN           = s_q.ovr;
    assign PROTECTED_START_SELECT = s_q.pstart;
    assign CODE_REMAP_BASE        = s_q.remap;
    assign SRAM_BASE              = s_q.sram;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence cs_rise_s;
        s_q.cs_s && !s_q.cs_p;
    endsequence
    sequence read_byte_s;
        bdone && (s_q.phase == FSP_DATA) && (s_q.op == OP_READ);
    endsequence

    read_status_cmd_load_a: assert property (
        (bdone && (s_q.phase == FSP_OP) && (rx == OP_RD_SR)) |=> (s_q.tx == $past(sr))
    ) else $error("status byte not loaded for read-status");
    read_incr_a: assert property (
        read_byte_s |=> (s_q.rd && (s_q.rd_addr == $past(s_q.addr) + 16'h0001)) ##2
                        (s_q.tx == ((s_q.rdis && !s_q.rd_info) ? 8'h00 : $past(FLASH_RDATA)))
    ) else $error("read address did not advance or data not loaded");
    rb_mask_a: assert property (
        (s_q.rdv && s_q.rdis && !s_q.rd_info) |=> (s_q.tx == 8'h00)
    ) else $error("main area data leaked while readback disabled");
    push_wen_a: assert property (
        push |-> s_q.wen
    ) else $error("flash write queued without write latch");
    prog_limit_a: assert property (
        push |-> (s_q.cnt < PROG_MAX)
    ) else $error("program burst exceeded limit");
    prog_wen_clr_a: assert property (
        (cs_rise_s ##0 (s_q.go && (s_q.op == OP_PROG))) |=> !s_q.wen
    ) else $error("write latch not cleared after program");
    erase_start_a: assert property (
        $rose(s_q.ers_pg) |-> $past(s_q.cs_s && !s_q.cs_p && s_q.wen)
    ) else $error("page erase started without select rise and latch");
    busy_ignore_a: assert property (
        (bdone && busy && (s_q.phase == FSP_OP) && (rx != OP_RD_SR)) |=>
        ((s_q.phase == FSP_IGN) [*2])
    ) else $error("command accepted during erase");
    erase_done_a: assert property (
        $fell(s_q.ers_pg) |-> (!s_q.wen && ($past(s_q.etmr) == ERASE_CYC - 16'h0001))
    ) else $error("page erase end wrong");
    sram_map_a: assert property (
        s_q.pstart |=> (s_q.sram == SRAM_HIGH)
    ) else $error("SRAM not at high base in protected start");
    start_sel_a: assert property (
        $rose(s_q.started) |-> (s_q.pstart == $past(nv_par))
    ) else $error("start select does not match parity");
endmodule : fsp_top

// >>> test/fsp_flash_model.sv
// Behavioural flash array behind the program port
`timescale 1ns/10ps
module fsp_flash_model (
    input  wire logic        clk,
    input  wire logic        hold,
    input  wire logic        rd,
    input  wire logic [15:0] ra,
    input  wire logic        ri,
    input  wire logic        wr,
    input  wire logic [15:0] wa,
    input  wire logic [7:0]  wd,
    input  wire logic        wi,
    output logic [7:0]       rdata,
    output logic             ready,
    output int               wcnt
);
    logic [7:0] mem [512];
    logic       tick_q = 1'b0;
    // Erased cells read as ones; only the low address byte is kept
    initial foreach (mem[i]) mem[i] = 8'hff;
    initial wcnt = 0;
    initial rdata = 8'h00;
    // Stalls every other cycle, and throughout while hold is set so the write queue backs up
    assign ready = tick_q & ~hold;
    always @(posedge clk) begin
        tick_q <= ~tick_q;
        // One cycle latency; valid only in its slot, a moving pattern elsewhere
        rdata <= rd ? mem[{ri, ra[7:0]}] : ~rdata;
        if (wr) begin
            mem[{wi, wa[7:0]}] <= wd;
            wcnt <= wcnt + 1;
        end
    end
endmodule : fsp_flash_model

// >>> test/fsp_top_tb.sv
// Self-checking bench for the flash SPI program port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module fsp_top_tb
    import fsp_pkg::*;
;
    logic SYS_CLK = 1'b0, SYS_RST = 1'b1, SPI_SCK = 1'b0, SPI_MOSI = 1'b0, hold = 1'b0;
    logic FLASH_CHIP_SELECT_N = 1'b1, SRAM_LOCATION_CTRL = 1'b0;
    logic [7:0] PROTECT_CONFIG_REG = 8'h04;
    logic [NV_TOP_W-1:0] NV_TOP = '0;
    logic SPI_MISO, SPI_MISO_OE, FLASH_RD, FLASH_RD_INFO, FLASH_WR, FLASH_WR_INFO, FLASH_READY;
    logic FLASH_ERASE_PAGE, FLASH_ERASE_ALL, FLASH_ERASE_INFO, READBACK_DISABLE, DEBUG_EN;
    logic PROG_OVERRUN, PROTECTED_START_SELECT;
    logic [15:0] FLASH_RD_ADDR, FLASH_WR_ADDR, CODE_REMAP_BASE, SRAM_BASE;
    logic [7:0]  FLASH_RDATA, FLASH_WR_DATA, FLASH_STATUS_REG;
    logic [5:0]  FLASH_PAGE;
    logic [7:0]  tq[$], rq[$];
    int fails = 0, comparisons = 0, cyc = 0, ecnt = 0, wcnt, n;

    fsp_top u_fsp_top (.SYS_CLK, .SYS_RST, .SPI_SCK, .SPI_MOSI, .FLASH_CHIP_SELECT_N,
        .SPI_MISO, .SPI_MISO_OE, .FLASH_RDATA, .FLASH_READY, .PROTECT_CONFIG_REG, .NV_TOP,
        .SRAM_LOCATION_CTRL, .FLASH_RD, .FLASH_RD_ADDR, .FLASH_RD_INFO, .FLASH_WR,
        .FLASH_WR_ADDR, .FLASH_WR_DATA, .FLASH_WR_INFO, .FLASH_ERASE_PAGE, .FLASH_ERASE_ALL,
        .FLASH_ERASE_INFO, .FLASH_PAGE, .FLASH_STATUS_REG, .READBACK_DISABLE, .DEBUG_EN,
        .PROG_OVERRUN, .PROTECTED_START_SELECT, .CODE_REMAP_BASE, .SRAM_BASE);
    fsp_flash_model u_fsp_flash_model (.clk(SYS_CLK), .hold, .rd(FLASH_RD), .ra(FLASH_RD_ADDR),
        .ri(FLASH_RD_INFO), .wr(FLASH_WR), .wa(FLASH_WR_ADDR), .wd(FLASH_WR_DATA),
        .wi(FLASH_WR_INFO), .rdata(FLASH_RDATA), .ready(FLASH_READY), .wcnt);

    always #25 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    // Counted away from the launching edge so the level is settled
    always @(negedge SYS_CLK) begin
        if (FLASH_ERASE_PAGE) ecnt++;
    end

    task automatic stop_test();
        $display("counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // One select frame, mode 0; MISO sampled late in the high phase
    task automatic go();
        logic [7:0] r;
        rq.delete();
        @(posedge SYS_CLK);
        #1 FLASH_CHIP_SELECT_N = 1'b0;
        #400;
        foreach (tq[i]) begin
            for (int b = 7; b >= 0; b--) begin
                SPI_MOSI = tq[i][b];
                #200 SPI_SCK = 1'b1;
                #150 r[b] = SPI_MISO;
                if (b == 0) `CHK("oe", 1'b1, SPI_MISO_OE)
                #50 SPI_SCK = 1'b0;
            end
            rq.push_back(r);
        end
        #400 FLASH_CHIP_SELECT_N = 1'b1;
        #400;
    endtask : go

    task automatic one(input logic [7:0] op);
        tq = '{op};
        go();
    endtask : one

    task automatic sr(input logic [7:0] e);
        tq = '{OP_RD_SR, 8'h00};
        go();
        `CHK("status", e, rq[1])
    endtask : sr

    task automatic restart(input logic [NV_TOP_W-1:0] nv);
        NV_TOP = nv;
        SYS_RST = 1'b1;
        repeat (2) @(posedge SYS_CLK);
        #1 SYS_RST = 1'b0;
        repeat (6) @(posedge SYS_CLK);
        #1;
    endtask : restart

    initial begin
        restart(128'h1);
        `CHK("start", 3'h5, {PROTECTED_START_SELECT, READBACK_DISABLE, SRAM_BASE[15]})
        `CHK("remap", 16'h0800, CODE_REMAP_BASE)
        `CHK("oe", 1'b0, SPI_MISO_OE)
        sr(8'h00);
        tq = '{OP_PROG, 8'hfe, 8'h01, 8'h11};
        go();
        `CHK("wr", 0, wcnt)
        one(OP_SET_WL);
        sr(8'h20);
        `CHK("fsr", 8'h20, FLASH_STATUS_REG)
        one(OP_CLR_WL);
        sr(8'h00);
        $display("test latch done");
        one(OP_SET_WL);
        hold = 1'b1;
        tq = '{OP_PROG, 8'hfe, 8'h01};
        for (int i = 0; i < 20; i++) tq.push_back(8'h10 + 8'(i));
        go();
        `CHK("ovr", 1'b1, PROG_OVERRUN)
        hold = 1'b0;
        for (n = 0; n < 200 && wcnt < 16; n++) @(posedge SYS_CLK);
        #1;
        `CHK("wr", 16, wcnt)
        sr(8'h00);
        tq = '{OP_READ, 8'hfe, 8'h01, 8'h00, 8'h00, 8'h00};
        go();
        `CHK("rd", 24'h121110, {rq[5], rq[4], rq[3]})
        tq = '{OP_READ, 8'hff, 8'hff, 8'h00, 8'h00};
        go();
        `CHK("wrap", 16'h1211, {rq[4], rq[3]})
        tq = '{OP_WR_SR, 8'h08};
        go();
        sr(8'h08);
        one(OP_SET_WL);
        tq = '{OP_PROG, 8'h05, 8'h00, 8'h77};
        go();
        tq = '{OP_READ, 8'h05, 8'h00, 8'h00};
        go();
        `CHK("info", 8'h77, rq[3])
        $display("test program done");
        tq = '{OP_ERS_PG, 8'h05};
        go();
        `CHK("noerase", 1'b0, FLASH_ERASE_PAGE)
        one(OP_SET_WL);
        tq = '{OP_ERS_PG, 8'h24};
        go();
        `CHK("badpage", 1'b0, FLASH_ERASE_PAGE)
        one(OP_SET_WL);
        tq = '{OP_ERS_PG, 8'h21};
        go();
        `CHK("page", 7'h61, {FLASH_ERASE_PAGE, FLASH_PAGE})
        one(OP_CLR_WL);
        sr(8'h38);
        for (n = 0; n < 500 && FLASH_ERASE_PAGE; n++) @(posedge SYS_CLK);
        #1;
        `CHK("ecnt", 400, ecnt)
        sr(8'h08);
        one(OP_SET_WL);
        one(OP_DBG_EN);
        `CHK("dbg", 1'b1, DEBUG_EN)
        one(OP_SET_WL);
        one(OP_ERS_ALL);
        `CHK("all", 2'b11, {FLASH_ERASE_ALL, FLASH_ERASE_INFO})
        for (n = 0; n < 500 && FLASH_ERASE_ALL; n++) @(posedge SYS_CLK);
        #1;
        `CHK("dbg", 1'b0, DEBUG_EN)
        $display("test erase done");
        tq = '{OP_WR_SR, 8'h00};
        go();
        tq = '{OP_RD_PCFG, 8'h00};
        go();
        `CHK("pcfg", 8'h04, rq[1])
        one(OP_SET_WL);
        one(OP_RB_DIS);
        `CHK("rdis", 1'b1, READBACK_DISABLE)
        tq = '{OP_READ, 8'h05, 8'h00, 8'h00};
        go();
        `CHK("hidden", 8'h00, rq[3])
        one(OP_SET_WL);
        tq = '{OP_PROG, 8'h00, 8'h00, 8'h55};
        go();
        `CHK("wr", 17, wcnt)
        restart(128'h3);
        `CHK("start", 3'h0, {PROTECTED_START_SELECT, READBACK_DISABLE, SRAM_BASE[15]})
        `CHK("remap", ADDR_ZERO, CODE_REMAP_BASE)
        SRAM_LOCATION_CTRL = 1'b1;
        @(posedge SYS_CLK);
        #1;
        `CHK("sram", 16'h8000, SRAM_BASE)
        $display("test protect done");
        stop_test();
    end
endmodule : fsp_top_tb
